// file: core/mthsr_pkg.sv
// Shared constants and types for the target, wrap, reference search and step table block
`default_nettype none
package mthsr_pkg;
  // Register indices, one data word each
  localparam logic [8:0] IDX_TARGET_SMOOTHING = 9'h1cd;
  localparam logic [8:0] IDX_TARGET_AT_REG    = 9'h1ce;
  localparam logic [8:0] IDX_WRAP_LOWER       = 9'h1d6;
  localparam logic [8:0] IDX_WRAP_UPPER       = 9'h1d8;
  localparam logic [8:0] IDX_SEARCH_STEPS     = 9'h1e0;
  localparam logic [8:0] IDX_OFFSET_SHORT     = 9'h1ea;
  localparam logic [8:0] IDX_SEARCH_SPEED     = 9'h1eb;
  localparam logic [8:0] IDX_SEARCH_ACCEL     = 9'h1ec;
  localparam logic [8:0] IDX_SEARCH_TORQUE    = 9'h1ed;
  localparam logic [8:0] IDX_DONE_NEXT_MODE   = 9'h1ee;
  localparam logic [8:0] IDX_ZERO_SHIFT       = 9'h1ef;
  localparam logic [8:0] IDX_OFFSET_LONG      = 9'h1f0;
  localparam logic [8:0] IDX_STEP_CONTROL     = 9'h1f4;
  localparam logic [8:0] IDX_STEP_POINTER     = 9'h1f5;
  localparam int         NUM_SEARCH_STEPS     = 4;

  // Reset values
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [31:0] RST_REG32 = 32'h0000_0000;

  // Value limits
  localparam logic [15:0] SEARCH_SPEED_MAX = 16'd25600;
  localparam logic [15:0] SEARCH_ACCEL_MAX = 16'd20000;
  localparam logic [15:0] SEARCH_TORQUE_MAX = 16'd2000;
  localparam logic [3:0]  SMOOTH_SHIFT_MAX = 4'hf;
  localparam int          SPEED_UNIT_SHIFT = 4;   // positions/s divided by 16
  localparam int          ACCEL_UNIT_SHIFT = 8;   // positions/s^2 divided by 256

  // Step table control fields
  localparam int CTL_DELAY_BIT  = 0;
  localparam int CTL_SCALE_LSB  = 1;
  localparam int CTL_REPEAT_BIT = 3;
  localparam logic [1:0] SCALE_MS  = 2'h0;
  localparam logic [1:0] SCALE_SEC = 2'h1;
  localparam logic [1:0] SCALE_MIN = 2'h2;

  // Reference search step descriptor: action code in the low nibble
  localparam int         STEP_ACT_LSB     = 0;
  localparam logic [3:0] ACT_END          = 4'h0;
  localparam logic [3:0] ACT_SENSOR_FWD   = 4'h1;
  localparam logic [3:0] ACT_SENSOR_REV   = 4'h2;
  localparam logic [3:0] ACT_HARDSTOP_FWD = 4'h3;
  localparam logic [3:0] ACT_HARDSTOP_REV = 4'h4;

  // Timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int MS_TICK_NS     = 1000000;
  localparam int MS_TICK_CYCLES = (MS_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] MS_PER_MS  = 16'd1;
  localparam logic [15:0] MS_PER_SEC = 16'd1000;
  localparam logic [15:0] MS_PER_MIN = 16'd60000;

  typedef enum logic [1:0] {H_IDLE, H_LOAD, H_MOVE, H_DONE} mthsr_home_e;
  typedef enum logic [1:0] {S_IDLE, S_ENTRY, S_WAIT_POS, S_TIMING} mthsr_seq_e;
endpackage : mthsr_pkg
`default_nettype wire

// file: core/mthsr_step_timer.sv
// Step timer for the position/time table with selectable time unit
`default_nettype none
module mthsr_step_timer
  import mthsr_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        load,
  input  wire logic [15:0] time_val,
  input  wire logic [1:0]  scale,
  output logic             expired
);
  localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

  logic [31:0] presc_ff;
  logic [15:0] ms_ff;
  logic [15:0] remain_ff;
  logic        run_ff;
  logic [15:0] unit_ms;
  logic        ms_tick;
  logic        unit_tick;

  // Unit select; code 3 falls back to milliseconds
  always_comb begin
    unique case (scale)
      SCALE_SEC: unit_ms = MS_PER_SEC;
      SCALE_MIN: unit_ms = MS_PER_MIN;
      default:   unit_ms = MS_PER_MS;
    endcase
  end

  assign ms_tick   = run_ff && (presc_ff == MS_LAST);
  assign unit_tick = ms_tick && (ms_ff == unit_ms - 16'h1);

  // Prescaler, unit counter and remaining count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_ff  <= 32'h0;
      ms_ff     <= 16'h0;
      remain_ff <= 16'h0;
      run_ff    <= 1'b0;
      expired   <= 1'b0;
    end else if (ce) begin
      expired <= 1'b0;
      if (load) begin
        presc_ff  <= 32'h0;
        ms_ff     <= 16'h0;
        remain_ff <= time_val;
        run_ff    <= (time_val != 16'h0);
      end else if (run_ff) begin
        presc_ff <= ms_tick ? 32'h0 : presc_ff + 32'h1;
        if (ms_tick) begin
          ms_ff <= unit_tick ? 16'h0 : ms_ff + 16'h1;
        end
        if (unit_tick) begin
          remain_ff <= remain_ff - 16'h1;
          if (remain_ff == 16'h1) begin
            run_ff  <= 1'b0;
            expired <= 1'b1;
          end
        end
      end
    end
  end
endmodule // mthsr_step_timer
`default_nettype wire

// file: core/mthsr_core.sv
// Target smoothing, rotary wrap, reference search and step table sequencing
//
// Summary of operation
// - Smooth target; zero setting passes straight through
// - Read back final target sent to regulator
// - Below lower bound wraps to upper minus one
// - Reaching upper bound wraps to lower bound
// - Search runs up to four steps in order
// - Search speed in positions/s over 16, max 25600
// - Search accel in positions/s^2 over 256
// - Hard stop search limits torque to setting
// - On completion load next operating mode
// - Report zero shift after each completed search
// - Reference gets signed 32-bit offset value
// - Delay mode 0: timer starts, advances regardless
// - Delay mode 1: timer starts once position reached
// - Scale 0 is milliseconds, 1 is seconds
// - Repeat 0 lets sequence end
// - Zero time ends sequence unless repeat set
// - Table pointer 0..15 advances per entry
`default_nettype none
module mthsr_core
  import mthsr_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_TICK_CYCLES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic        CE,
  input  wire logic [8:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  input  wire logic [31:0] TARGET_IN,
  output logic      [31:0] TARGET_OUT,
  input  wire logic        ROTARY_MODE,
  input  wire logic        POS_UP,
  input  wire logic        POS_DN,
  output logic      [31:0] MOTOR_POS,
  input  wire logic        SEARCH_START,
  input  wire logic        HOME_SENSOR,
  input  wire logic        HARD_STOP_HIT,
  output logic             SEARCH_ACTIVE,
  output logic             SEARCH_REVERSE,
  output logic      [31:0] SEARCH_SPEED,
  output logic      [31:0] SEARCH_ACCEL,
  output logic             TORQUE_LIMIT_EN,
  output logic      [15:0] TORQUE_LIMIT,
  output logic      [15:0] NEXT_MODE,
  output logic             NEXT_MODE_LOAD,
  input  wire logic        SEQ_RUN,
  input  wire logic [15:0] SEQ_TIME,
  input  wire logic        SEQ_AT_TARGET,
  output logic      [3:0]  STEP_POINTER,
  output logic             SEQ_ACTIVE,
  output logic             SEQ_ENDED
);
  logic [15:0]        smoothing_ff;
  logic signed [31:0] lower_ff;
  logic signed [31:0] upper_ff;
  logic [15:0]        steps_ff [NUM_SEARCH_STEPS];
  logic [15:0]        offset_short_ff;
  logic [15:0]        speed_ff;
  logic [15:0]        accel_ff;
  logic [15:0]        torque_ff;
  logic [15:0]        done_mode_ff;
  logic [15:0]        zero_shift_ff;
  logic signed [31:0] offset_long_ff;
  logic [15:0]        control_ff;
  logic [3:0]         pointer_ff;
  logic signed [31:0] filt_ff;
  logic signed [31:0] pos_ff;
  logic signed [31:0] nxt_pos;
  logic [31:0]        nxt_rdata;
  logic [31:0]        rdata_ff;
  logic               sens_meta_ff;
  logic               sens_ff;
  mthsr_home_e        home_ff;
  logic [1:0]         step_idx_ff;
  logic [3:0]         act_ff;
  logic               search_done;
  mthsr_seq_e         seq_ff;
  logic               ended_ff;
  logic               timer_load;
  logic               timer_expired;
  logic               advance;
  logic               wr_hit;
  logic [3:0]         shamt;
  logic signed [32:0] diff;
  logic signed [32:0] step_amt;
  logic               delay_mode;
  logic               repeat_on;

  assign wr_hit     = REG_WR;
  assign delay_mode = control_ff[CTL_DELAY_BIT];
  assign repeat_on  = control_ff[CTL_REPEAT_BIT];

  // Software-written configuration; out-of-range speed, accel and torque values are clamped at the write
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      smoothing_ff    <= RST_REG16;
      lower_ff        <= RST_REG32;
      upper_ff        <= RST_REG32;
      offset_short_ff <= RST_REG16;
      speed_ff        <= RST_REG16;
      accel_ff        <= RST_REG16;
      torque_ff       <= RST_REG16;
      done_mode_ff    <= RST_REG16;
      offset_long_ff  <= RST_REG32;
      control_ff      <= RST_REG16;
    end else if (CE && wr_hit) begin
      unique case (REG_ADDR)
        IDX_TARGET_SMOOTHING: smoothing_ff    <= REG_WDATA[15:0];
        IDX_WRAP_LOWER:       lower_ff        <= REG_WDATA;
        IDX_WRAP_UPPER:       upper_ff        <= REG_WDATA;
        IDX_OFFSET_SHORT: begin
          // Short form is kept for old software and sign-extended into the long one
          offset_short_ff <= REG_WDATA[15:0];
          offset_long_ff  <= {{16{REG_WDATA[15]}}, REG_WDATA[15:0]};
        end
        IDX_SEARCH_SPEED: begin
          speed_ff <= (REG_WDATA[15:0] > SEARCH_SPEED_MAX) ? SEARCH_SPEED_MAX
                                                           : REG_WDATA[15:0];
        end
        IDX_SEARCH_ACCEL: begin
          accel_ff <= (REG_WDATA[15:0] > SEARCH_ACCEL_MAX) ? SEARCH_ACCEL_MAX
                                                           : REG_WDATA[15:0];
        end
        IDX_SEARCH_TORQUE: begin
          torque_ff <= (REG_WDATA[15:0] > SEARCH_TORQUE_MAX) ? SEARCH_TORQUE_MAX
                                                             : REG_WDATA[15:0];
        end
        IDX_DONE_NEXT_MODE:   done_mode_ff    <= REG_WDATA[15:0];
        IDX_OFFSET_LONG:      offset_long_ff  <= REG_WDATA;
        IDX_STEP_CONTROL:     control_ff      <= REG_WDATA[15:0];
        default: ;
      endcase
    end
  end

  // One register per search step descriptor
  for (genvar g = 0; g < NUM_SEARCH_STEPS; g++) begin : g_steps
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
        steps_ff[g] <= RST_REG16;
      end else if (CE && wr_hit && REG_ADDR == IDX_SEARCH_STEPS + 9'(g)) begin
        steps_ff[g] <= REG_WDATA[15:0];
      end
    end
  end

  // Read mux; unmapped indices read zero
  always_comb begin
    nxt_rdata = 32'h0;
    if (REG_ADDR >= IDX_SEARCH_STEPS &&
        REG_ADDR < IDX_SEARCH_STEPS + 9'(NUM_SEARCH_STEPS)) begin
      nxt_rdata = {16'h0, steps_ff[REG_ADDR[1:0]]};
    end else begin
      unique case (REG_ADDR)
        IDX_TARGET_SMOOTHING: nxt_rdata = {16'h0, smoothing_ff};
        IDX_TARGET_AT_REG:    nxt_rdata = filt_ff;
        IDX_WRAP_LOWER:       nxt_rdata = lower_ff;
        IDX_WRAP_UPPER:       nxt_rdata = upper_ff;
        IDX_OFFSET_SHORT:     nxt_rdata = {16'h0, offset_short_ff};
        IDX_SEARCH_SPEED:     nxt_rdata = {16'h0, speed_ff};
        IDX_SEARCH_ACCEL:     nxt_rdata = {16'h0, accel_ff};
        IDX_SEARCH_TORQUE:    nxt_rdata = {16'h0, torque_ff};
        IDX_DONE_NEXT_MODE:   nxt_rdata = {16'h0, done_mode_ff};
        IDX_ZERO_SHIFT:       nxt_rdata = {16'h0, zero_shift_ff};
        IDX_OFFSET_LONG:      nxt_rdata = offset_long_ff;
        IDX_STEP_CONTROL:     nxt_rdata = {16'h0, control_ff};
        IDX_STEP_POINTER:     nxt_rdata = {28'h0, pointer_ff};
        default:              nxt_rdata = 32'h0;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_ff <= 32'h0;
    end else if (CE) begin
      rdata_ff <= REG_RD ? nxt_rdata : 32'h0;
    end
  end
  assign REG_RDATA = rdata_ff;

  // First-order smoothing: a larger shift slows the approach; each step is the gap shifted right
  assign shamt    = (smoothing_ff > 16'(SMOOTH_SHIFT_MAX)) ? SMOOTH_SHIFT_MAX
                                                            : smoothing_ff[3:0];
  assign diff     = $signed({TARGET_IN[31], TARGET_IN}) - $signed({filt_ff[31], filt_ff});
  assign step_amt = diff >>> shamt;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      filt_ff <= RST_REG32;
    end else if (CE) begin
      filt_ff <= filt_ff + step_amt[31:0];
    end
  end
  assign TARGET_OUT = filt_ff;

  // Position counter with rotary wrap; search completion re-bases it
  always_comb begin
    nxt_pos = pos_ff;
    if (search_done) begin
      nxt_pos = offset_long_ff;
    end else if (POS_UP && !POS_DN) begin
      if (ROTARY_MODE && pos_ff >= upper_ff - 32'sd1) begin
        nxt_pos = lower_ff;
      end else begin
        nxt_pos = pos_ff + 32'sd1;
      end
    end else if (POS_DN && !POS_UP) begin
      if (ROTARY_MODE && pos_ff <= lower_ff) begin
        nxt_pos = upper_ff - 32'sd1;
      end else begin
        nxt_pos = pos_ff - 32'sd1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pos_ff <= RST_REG32;
    end else if (CE) begin
      pos_ff <= nxt_pos;
    end
  end
  assign MOTOR_POS = pos_ff;

  // Sensor pin synchroniser
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sens_meta_ff <= 1'b0;
      sens_ff      <= 1'b0;
    end else if (CE) begin
      sens_meta_ff <= HOME_SENSOR;
      sens_ff      <= sens_meta_ff;
    end
  end

  // Reference search sequencer walking the step descriptors in order
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      home_ff     <= H_IDLE;
      step_idx_ff <= 2'h0;
      act_ff      <= ACT_END;
    end else if (CE) begin
      unique case (home_ff)
        H_IDLE: begin
          if (SEARCH_START) begin
            step_idx_ff <= 2'h0;
            home_ff     <= H_LOAD;
          end
        end
        H_LOAD: begin
          act_ff  <= steps_ff[step_idx_ff][STEP_ACT_LSB +: 4];
          home_ff <= (steps_ff[step_idx_ff][STEP_ACT_LSB +: 4] == ACT_END) ? H_DONE : H_MOVE;
        end
        H_MOVE: begin
          // Unknown action codes finish their step at once
          if (((act_ff == ACT_SENSOR_FWD || act_ff == ACT_SENSOR_REV) && sens_ff) ||
              ((act_ff == ACT_HARDSTOP_FWD || act_ff == ACT_HARDSTOP_REV) && HARD_STOP_HIT) ||
              act_ff > ACT_HARDSTOP_REV) begin
            step_idx_ff <= step_idx_ff + 2'h1;
            home_ff     <= (step_idx_ff == 2'(NUM_SEARCH_STEPS - 1)) ? H_DONE : H_LOAD;
          end
        end
        H_DONE: begin
          act_ff  <= ACT_END;
          home_ff <= H_IDLE;
        end
      endcase
    end
  end

  assign search_done = (home_ff == H_DONE);

  // Zero shift is the old-frame position of the new zero point
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      zero_shift_ff  <= RST_REG16;
      NEXT_MODE      <= RST_REG16;
      NEXT_MODE_LOAD <= 1'b0;
    end else if (CE) begin
      NEXT_MODE_LOAD <= search_done;
      if (search_done) begin
        zero_shift_ff <= 16'(pos_ff - offset_long_ff);
        NEXT_MODE     <= done_mode_ff;
      end
    end
  end

  // Motion demands during the search
  assign SEARCH_ACTIVE   = (home_ff == H_MOVE);
  assign SEARCH_REVERSE  = (act_ff == ACT_SENSOR_REV || act_ff == ACT_HARDSTOP_REV);
  assign SEARCH_SPEED    = {12'h0, speed_ff, 4'h0};
  assign SEARCH_ACCEL    = {8'h0, accel_ff, 8'h0};
  assign TORQUE_LIMIT_EN = SEARCH_ACTIVE &&
                           (act_ff == ACT_HARDSTOP_FWD || act_ff == ACT_HARDSTOP_REV);
  assign TORQUE_LIMIT    = torque_ff;

  // Step table sequencer
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      seq_ff   <= S_IDLE;
      ended_ff <= 1'b0;
    end else if (CE) begin
      if (!SEQ_RUN) begin
        seq_ff   <= S_IDLE;
        ended_ff <= 1'b0;
      end else begin
        unique case (seq_ff)
          S_IDLE: begin
            if (!ended_ff) begin
              seq_ff <= S_ENTRY;
            end
          end
          S_ENTRY: begin
            if (SEQ_TIME == 16'h0 && !repeat_on) begin
              seq_ff   <= S_IDLE;
              ended_ff <= 1'b1;
            end else if (SEQ_TIME == 16'h0) begin
              seq_ff <= S_ENTRY;
            end else if (delay_mode) begin
              seq_ff <= S_WAIT_POS;
            end else begin
              seq_ff <= S_TIMING;
            end
          end
          S_WAIT_POS: begin
            if (SEQ_AT_TARGET) begin
              seq_ff <= S_TIMING;
            end
          end
          S_TIMING: begin
            if (timer_expired) begin
              seq_ff <= S_ENTRY;
            end
          end
        endcase
      end
    end
  end

  assign timer_load = SEQ_RUN && (((seq_ff == S_ENTRY) && SEQ_TIME != 16'h0 && !delay_mode) ||
                                  ((seq_ff == S_WAIT_POS) && SEQ_AT_TARGET));
  assign advance    = SEQ_RUN && (((seq_ff == S_TIMING) && timer_expired) ||
                                  ((seq_ff == S_ENTRY) && SEQ_TIME == 16'h0 && repeat_on));

  // Pointer wraps 15 to 0; an advance beats a software write in the same cycle
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pointer_ff <= 4'h0;
    end else if (CE) begin
      if (advance) begin
        pointer_ff <= pointer_ff + 4'h1;
      end else if (wr_hit && REG_ADDR == IDX_STEP_POINTER) begin
        pointer_ff <= REG_WDATA[3:0];
      end
    end
  end

  mthsr_step_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .clk      (CORE_CLK),
    .rst_n    (RSTN),
    .ce       (CE),
    .load     (timer_load),
    .time_val (SEQ_TIME),
    .scale    (control_ff[CTL_SCALE_LSB +: 2]),
    .expired  (timer_expired)
  );

  assign STEP_POINTER = pointer_ff;
  assign SEQ_ACTIVE   = (seq_ff != S_IDLE);
  assign SEQ_ENDED    = ended_ff;
endmodule // mthsr_core
`default_nettype wire

// file: dv/mthsr_asserts.sv
// Port-level assertions for the target, wrap, search and step table core
`default_nettype none
module mthsr_asserts (
  input wire logic        CORE_CLK,
  input wire logic        RSTN,
  input wire logic        CE,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic        ROTARY_MODE,
  input wire logic        POS_UP,
  input wire logic        POS_DN,
  input wire logic [31:0] MOTOR_POS,
  input wire logic        SEARCH_ACTIVE,
  input wire logic [31:0] SEARCH_SPEED,
  input wire logic [31:0] SEARCH_ACCEL,
  input wire logic        TORQUE_LIMIT_EN,
  input wire logic [15:0] TORQUE_LIMIT,
  input wire logic [15:0] NEXT_MODE,
  input wire logic        NEXT_MODE_LOAD,
  input wire logic        SEQ_RUN,
  input wire logic [15:0] SEQ_TIME,
  input wire logic [3:0]  STEP_POINTER,
  input wire logic        SEQ_ACTIVE,
  input wire logic        SEQ_ENDED
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);

  // Sequence start request and its stop request
  sequence s_run_req;
    CE && SEQ_RUN && !SEQ_ACTIVE && !SEQ_ENDED;
  endsequence
  sequence s_stop_req;
    CE && !SEQ_RUN;
  endsequence

  AST_RDATA_IDLE: assert property (
    $past(CE) && !$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data not zero outside its slot");
  AST_SPEED_UNIT: assert property (
    SEARCH_SPEED[3:0] == 4'h0 && SEARCH_SPEED <= 32'h64000)
    else $error("search speed scaling wrong");
  AST_ACCEL_UNIT: assert property (
    SEARCH_ACCEL[7:0] == 8'h0 && SEARCH_ACCEL <= 32'h4e2000)
    else $error("search accel scaling wrong");
  AST_TORQUE_HOLD: assert property (
    TORQUE_LIMIT_EN |-> SEARCH_ACTIVE && TORQUE_LIMIT <= 16'h7d0)
    else $error("torque limit outside a search move");
  AST_LOAD_PULSE: assert property (
    NEXT_MODE_LOAD |=> !NEXT_MODE_LOAD)
    else $error("mode load longer than one cycle");
  AST_MODE_WITH_LOAD: assert property (
    $changed(NEXT_MODE) |-> NEXT_MODE_LOAD)
    else $error("next mode changed without load");
  AST_POS_STEP: assert property (
    CE && POS_UP && !POS_DN && !ROTARY_MODE
      |=> NEXT_MODE_LOAD || MOTOR_POS == $past(MOTOR_POS) + 32'h1)
    else $error("position did not count up");
  AST_PTR_STEP: assert property (
    SEQ_ACTIVE && CE && !REG_WR
      |=> STEP_POINTER == $past(STEP_POINTER) || STEP_POINTER == $past(STEP_POINTER) + 4'h1)
    else $error("table pointer jumped");
  AST_END_ON_ZERO: assert property (
    $rose(SEQ_ENDED) |-> !SEQ_ACTIVE && $past(SEQ_TIME) == 16'h0)
    else $error("sequence ended without zero time");
  AST_RUN_START: assert property (
    s_run_req |=> SEQ_ACTIVE)
    else $error("sequence did not start");
  AST_STOP_CLEAR: assert property (
    s_stop_req |=> !SEQ_ACTIVE && !SEQ_ENDED)
    else $error("sequence did not stop");
endmodule // mthsr_asserts

bind mthsr_core mthsr_asserts u_asserts (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .CE(CE), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .ROTARY_MODE(ROTARY_MODE), .POS_UP(POS_UP), .POS_DN(POS_DN),
  .MOTOR_POS(MOTOR_POS), .SEARCH_ACTIVE(SEARCH_ACTIVE), .SEARCH_SPEED(SEARCH_SPEED),
  .SEARCH_ACCEL(SEARCH_ACCEL), .TORQUE_LIMIT_EN(TORQUE_LIMIT_EN),
  .TORQUE_LIMIT(TORQUE_LIMIT), .NEXT_MODE(NEXT_MODE), .NEXT_MODE_LOAD(NEXT_MODE_LOAD),
  .SEQ_RUN(SEQ_RUN), .SEQ_TIME(SEQ_TIME), .STEP_POINTER(STEP_POINTER),
  .SEQ_ACTIVE(SEQ_ACTIVE), .SEQ_ENDED(SEQ_ENDED));
`default_nettype wire

// file: dv/motor_target_homing_sequence_regs_bench.sv
// Self-checking bench for the target, wrap, reference search and step table core
`default_nettype none
module motor_target_homing_sequence_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rstn, rd, wr, rot, up, dn, start, sens, hit, run, at_tgt, ce, rev;
  logic [8:0]  addr;
  logic [31:0] wdata, rdata, tgt_in, tgt_out, pos, spd, acc;
  logic [15:0] tq, nmode, stime;
  logic [3:0]  ptr;
  logic        s_act, tq_en, nm_ld, q_act, q_end;
  logic [15:0] tab [16];
  logic [8:0]  map [18] = '{9'h1cd, 9'h1ce, 9'h1d6, 9'h1d8, 9'h1e0, 9'h1e1, 9'h1e2, 9'h1e3,
                            9'h1ea, 9'h1eb, 9'h1ec, 9'h1ed, 9'h1ee, 9'h1ef, 9'h1f0, 9'h1f4,
                            9'h1f5, 9'h100};
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          i;

  // Short timer unit keeps the second-scale case to a few thousand cycles
  mthsr_core #(.MS_CYCLES(4)) u_dut (
    .CORE_CLK(clk), .RSTN(rstn), .CE(ce), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .TARGET_IN(tgt_in), .TARGET_OUT(tgt_out),
    .ROTARY_MODE(rot), .POS_UP(up), .POS_DN(dn), .MOTOR_POS(pos), .SEARCH_START(start),
    .HOME_SENSOR(sens), .HARD_STOP_HIT(hit), .SEARCH_ACTIVE(s_act), .SEARCH_REVERSE(rev),
    .SEARCH_SPEED(spd), .SEARCH_ACCEL(acc), .TORQUE_LIMIT_EN(tq_en), .TORQUE_LIMIT(tq),
    .NEXT_MODE(nmode), .NEXT_MODE_LOAD(nm_ld), .SEQ_RUN(run), .SEQ_TIME(stime),
    .SEQ_AT_TARGET(at_tgt), .STEP_POINTER(ptr), .SEQ_ACTIVE(q_act), .SEQ_ENDED(q_end));

  // External time table, looked up combinationally like a memory read
  assign stime = tab[ptr];

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Watchdog against a hung wait
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe
  task automatic rchk(input logic [8:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic step(input logic u, input logic d, input logic [31:0] exp);
    @(posedge clk);
    up <= u;
    dn <= d;
    @(posedge clk);
    up <= 1'b0;
    dn <= 1'b0;
    #1;
    chk(pos, exp);
  endtask

  // Run the table from pointer p0; check pointer after e edges, then {ended,ptr} l later
  task automatic seq(input logic [3:0] ctl, input logic [3:0] p0, input logic a, input int e,
                     input logic [3:0] ep, input int l, input logic [4:0] lp);
    wreg(9'h1f4, 32'(ctl));
    wreg(9'h1f5, 32'(p0));
    @(posedge clk);
    at_tgt <= a;
    run <= 1'b1;
    repeat (e) @(posedge clk);
    #1;
    chk(32'(ptr), 32'(ep));
    repeat (l) @(posedge clk);
    #1;
    chk(32'({q_end, ptr}), 32'(lp));
    @(posedge clk);
    run <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    {rd, wr, rot, up, dn, start, sens, hit, run, at_tgt} = '0;
    rstn = 1'b0;
    ce = 1'b1;
    addr = 9'h0;
    wdata = 32'h0;
    tgt_in = 32'h0;
    foreach (tab[k]) tab[k] = 16'h64;
    tab[0] = 16'h2;
    tab[3] = 16'h1;
    tab[5] = 16'h2;
    tab[6] = 16'h0;
    tab[15] = 16'h2;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    // Reset values, upper half of a 16-bit slot dropped, read-only slot, unmapped slot, clamps and offset aliasing
    foreach (map[k]) rchk(map[k], 32'h0);
    wreg(9'h1cd, 32'hffff_0000);
    rchk(9'h1cd, 32'h0);
    wreg(9'h1ce, 32'h1234_5678);
    rchk(9'h1ce, 32'h0);
    wreg(9'h100, 32'h1);
    rchk(9'h100, 32'h0);
    wreg(9'h1eb, 32'h6401);
    rchk(9'h1eb, 32'h6400);
    chk(spd, 32'h64000);
    wreg(9'h1ec, 32'h4e21);
    rchk(9'h1ec, 32'h4e20);
    chk(acc, 32'h4e2000);
    wreg(9'h1ed, 32'h7d1);
    rchk(9'h1ed, 32'h7d0);
    wreg(9'h1ea, 32'hfff0);
    rchk(9'h1f0, 32'hffff_fff0);
    // Pass-through, then a shift of two moves a quarter of the gap per cycle
    @(posedge clk);
    tgt_in <= 32'h100;
    repeat (2) @(posedge clk);
    #1;
    chk(tgt_out, 32'h100);
    rchk(9'h1ce, 32'h100);
    wreg(9'h1cd, 32'h2);
    @(posedge clk);
    tgt_in <= 32'h200;
    @(posedge clk);
    #1;
    chk(tgt_out, 32'h140);
    @(posedge clk);
    #1;
    chk(tgt_out, 32'h170);
    // Rotary wrap between 10 and 20 both ways, then a plain count
    wreg(9'h1d6, 32'ha);
    wreg(9'h1d8, 32'h14);
    rchk(9'h1d8, 32'h14);
    @(posedge clk);
    rot <= 1'b1;
    step(1'b0, 1'b1, 32'h13);
    step(1'b1, 1'b0, 32'ha);
    step(1'b0, 1'b1, 32'h13);
    step(1'b1, 1'b0, 32'ha);
    @(posedge clk);
    rot <= 1'b0;
    step(1'b1, 1'b0, 32'hb);
    // Clock enable low must swallow a count pulse
    @(posedge clk);
    ce <= 1'b0;
    up <= 1'b1;
    @(posedge clk);
    ce <= 1'b1;
    up <= 1'b0;
    #1;
    chk(pos, 32'hb);
    // Search: hard stop step, sensor step, end code in the third slot
    wreg(9'h1e0, 32'h3);
    wreg(9'h1e1, 32'h1);
    wreg(9'h1ee, 32'hc8);
    wreg(9'h1f0, 32'h100);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    for (i = 0; i < 9 && !s_act; i++) #40;
    chk(32'({s_act, tq_en, rev, tq}), 32'h607d0);
    @(posedge clk);
    hit <= 1'b1;
    @(posedge clk);
    hit <= 1'b0;
    #1;
    for (i = 0; i < 9 && !s_act; i++) #40;
    chk(32'({s_act, tq_en, rev}), 32'h4);
    @(posedge clk);
    sens <= 1'b1;
    #1;
    for (i = 0; i < 12 && !nm_ld; i++) #40;
    chk(32'({nm_ld, nmode}), 32'h100c8);
    chk(pos, 32'h100);
    @(posedge clk);
    sens <= 1'b0;
    rchk(9'h1ef, 32'hff0b);
    // Step table: units, zero-time ending, repeat, wrap and delay mode
    seq(4'h0, 4'h0, 1'b0, 5, 4'h0, 12, 5'h01);
    seq(4'h2, 4'h3, 1'b0, 3900, 4'h3, 200, 5'h04);
    seq(4'h4, 4'h3, 1'b0, 4100, 4'h3, 0, 5'h03);
    seq(4'h0, 4'h5, 1'b0, 5, 4'h5, 15, 5'h16);
    seq(4'h8, 4'h5, 1'b0, 5, 4'h5, 15, 5'h07);
    seq(4'h0, 4'hf, 1'b0, 5, 4'hf, 12, 5'h00);
    seq(4'h1, 4'h0, 1'b0, 5, 4'h0, 35, 5'h00);
    seq(4'h1, 4'h0, 1'b1, 5, 4'h0, 14, 5'h01);
    end_of_test();
  end
endmodule // motor_target_homing_sequence_regs_bench
`default_nettype wire
